// ---- verilog/itc_pkg.sv ----
// interval counter package: register map, fields, reset values, timing
// Operation
// - timeouts reach from one 128th of a second up to 255 hours
// - counting runs from the crystal tick, independent of core power-down
// - interval counter steps on overflow of the selected time counter
// - equality with compare value sets match flag, interrupt if enabled
// - match in power-down with interrupt enabled wakes, vector 0053H
// - software may preload time registers while stopped, counting then continues from them
// - nine registers, one control register for enables, timebase and flags
// - interval counter is 8 bits, compared with the compare value
// - compare value register at index A6H, reset 00H, range 0 to 255
package itc_pkg;
    // register indices, byte address is four times the index
    localparam logic [7:0] IDX_CTRL = 8'hA1;
    localparam logic [7:0] IDX_HTH = 8'hA2;
    localparam logic [7:0] IDX_SEC = 8'hA3;
    localparam logic [7:0] IDX_MIN = 8'hA4;
    localparam logic [7:0] IDX_HOUR = 8'hA5;
    localparam logic [7:0] IDX_CMP = 8'hA6;
    localparam logic [7:0] IDX_IST = 8'hB0;
    localparam logic [7:0] IDX_ICLR = 8'hB1;
    localparam logic [7:0] IDX_IEN = 8'hB2;
    // control register fields
    localparam int BIT_CLK_EN = 0;
    localparam int BIT_CNT_EN = 1;
    localparam int BIT_MATCH = 2;
    localparam int BIT_SINGLE = 3;
    localparam int BIT_SEL_LO = 4;
    localparam int BIT_SEL_HI = 5;
    localparam int BIT_FMT = 6;
    // reset values
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_CMP = 8'h00;
    localparam logic [7:0] RST_TIME = 8'h00;
    // timing: core clock rate and the 1/128 s time base
    localparam int CLK_HZ = 250_000_000;
    localparam int TICKS_PER_SEC = 128;
    localparam int TICK_CYC = CLK_HZ / TICKS_PER_SEC;
    // time counter limits
    localparam logic [7:0] HTH_MAX = 8'h7F;
    localparam logic [7:0] SEC_MAX = 8'h3B;
    localparam logic [7:0] MIN_MAX = 8'h3B;
    localparam logic [7:0] HR24_MAX = 8'h17;
    localparam logic [7:0] HR255_MAX = 8'hFF;
    // wake-up service address
    localparam logic [15:0] WAKE_VEC = 16'h0053;
    // interval time base selection
    typedef enum logic [1:0] {
        ITC_TB_TICK = 2'h0,
        ITC_TB_SEC = 2'h1,
        ITC_TB_MIN = 2'h2,
        ITC_TB_HOUR = 2'h3
    } itc_tb_t;
endpackage : itc_pkg

// ---- verilog/itc_tod_if.sv ----
// time-of-day counter bundle between controller and counter module
`timescale 1ns/1ns
`default_nettype none
interface itc_tod_if;
    logic tick;
    logic run;
    logic fmt24;
    logic [3:0] wr;
    logic [7:0] wdata;
    logic [7:0] hth;
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hr;
    logic [3:0] ovf;
    modport ctl (output tick, run, fmt24, wr, wdata, input hth, sec, min, hr, ovf);
    modport tod (input tick, run, fmt24, wr, wdata, output hth, sec, min, hr, ovf);
endinterface : itc_tod_if
`default_nettype wire

// ---- verilog/itc_prescale.sv ----
// divider giving the 1/128 s tick as a one-cycle enable
`timescale 1ns/1ns
`default_nettype none
module itc_prescale #(
    parameter int DIV = itc_pkg::TICK_CYC
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // tick enable
    output logic o_tick
);
    localparam int W = $clog2(DIV);
    localparam logic [W-1:0] LAST = W'(DIV - 1);
    logic [W-1:0] cnt;
    // free-running, never gated by power-down
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            cnt <= '0;
            o_tick <= 1'b0;
        end else begin
            o_tick <= (cnt == LAST);
            cnt <= (cnt == LAST) ? '0 : cnt + 1'b1;
        end
    end
endmodule : itc_prescale
`default_nettype wire

// ---- verilog/itc_tod.sv ----
// hundredths, seconds, minutes and hours counters with overflow pulses
`timescale 1ns/1ns
`default_nettype none
module itc_tod (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // controller side
    itc_tod_if.tod bus
);
    logic c0;
    logic c1;
    logic c2;
    logic [7:0] hmax;
    // carry chain through the counters
    assign c0 = bus.tick & bus.run & (bus.hth == itc_pkg::HTH_MAX);
    assign c1 = c0 & (bus.sec == itc_pkg::SEC_MAX);
    assign c2 = c1 & (bus.min == itc_pkg::MIN_MAX);
    assign hmax = bus.fmt24 ? itc_pkg::HR24_MAX : itc_pkg::HR255_MAX;
    // counting while running, preload while stopped
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            bus.hth <= itc_pkg::RST_TIME;
            bus.sec <= itc_pkg::RST_TIME;
            bus.min <= itc_pkg::RST_TIME;
            bus.hr <= itc_pkg::RST_TIME;
            bus.ovf <= 4'h0;
        end else begin
            bus.ovf <= {c2, c1, c0, bus.tick & bus.run};
            if (bus.run) begin
                if (bus.tick) bus.hth <= c0 ? 8'h00 : bus.hth + 8'h01;
                if (c0) bus.sec <= c1 ? 8'h00 : bus.sec + 8'h01;
                if (c1) bus.min <= c2 ? 8'h00 : bus.min + 8'h01;
                if (c2) bus.hr <= (bus.hr == hmax) ? 8'h00 : bus.hr + 8'h01;
            end else begin
                if (bus.wr[0]) bus.hth <= bus.wdata;
                if (bus.wr[1]) bus.sec <= bus.wdata;
                if (bus.wr[2]) bus.min <= bus.wdata;
                if (bus.wr[3]) bus.hr <= bus.wdata;
            end
        end
    end
endmodule : itc_tod
`default_nettype wire

// ---- verilog/itc_top.sv ----
// interval counter unit: apb registers, interval compare, interrupt, wake
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ns
`default_nettype none
module itc_top #(
    parameter int TICK_CYCLES = itc_pkg::TICK_CYC
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic o_pready,
    output logic [31:0] o_prdata,
    output logic o_pslverr,
    // power state from the core
    input wire logic i_power_down,
    // interrupt and wake
    output logic o_irq,
    output logic o_wake,
    output logic [15:0] o_wake_vector
);
    // register hit on a word address
    function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
        return (a == {2'h0, idx, 2'h0});
    endfunction : hit

    itc_tod_if tod_bus ();
    logic tick128;
    logic fmt24;
    logic [1:0] sel;
    logic single;
    logic match;
    logic cnt_en;
    logic clk_en;
    logic [7:0] cmp;
    logic [7:0] icnt;
    logic [7:0] nxt;
    logic ist;
    logic ien;
    logic access;
    logic wr_fire;
    logic wr_ctrl;
    logic adv;
    logic hit_now;
    logic mapped;

    // tick source
    itc_prescale #(
        .DIV(TICK_CYCLES)
    ) u_pre (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .o_tick(tick128)
    );

    // time-of-day counters
    itc_tod u_tod (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .bus(tod_bus)
    );

    // apb access phase decode
    assign access = i_psel & i_penable;
    assign wr_fire = access & o_pready & i_pwrite;
    assign wr_ctrl = wr_fire & hit(i_paddr, itc_pkg::IDX_CTRL);
    assign mapped = hit(i_paddr, itc_pkg::IDX_CTRL)
        | hit(i_paddr, itc_pkg::IDX_HTH)
        | hit(i_paddr, itc_pkg::IDX_SEC)
        | hit(i_paddr, itc_pkg::IDX_MIN)
        | hit(i_paddr, itc_pkg::IDX_HOUR)
        | hit(i_paddr, itc_pkg::IDX_CMP)
        | hit(i_paddr, itc_pkg::IDX_IST)
        | hit(i_paddr, itc_pkg::IDX_ICLR)
        | hit(i_paddr, itc_pkg::IDX_IEN);

    // drive the time counters
    assign tod_bus.tick = tick128;
    assign tod_bus.run = clk_en;
    assign tod_bus.fmt24 = fmt24;
    assign tod_bus.wdata = i_pwdata[7:0];
    // time registers only take writes while counting is stopped
    assign tod_bus.wr[0] = wr_fire & ~clk_en & hit(i_paddr, itc_pkg::IDX_HTH);
    assign tod_bus.wr[1] = wr_fire & ~clk_en & hit(i_paddr, itc_pkg::IDX_SEC);
    assign tod_bus.wr[2] = wr_fire & ~clk_en & hit(i_paddr, itc_pkg::IDX_MIN);
    assign tod_bus.wr[3] = wr_fire & ~clk_en & hit(i_paddr, itc_pkg::IDX_HOUR);

    // interval advance and compare
    assign adv = cnt_en & tod_bus.ovf[sel];
    assign nxt = icnt + 8'h01;
    assign hit_now = adv & (nxt == cmp);

    // apb answer: one wait state, then ready with data
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
        end else begin
            o_pready <= access & ~o_pready;
            o_pslverr <= access & ~o_pready & ~mapped;
        end
    end

    // read data capture
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_prdata <= 32'h0000_0000;
        end else if (access & ~o_pready & ~i_pwrite) begin
            o_prdata <= 32'h0000_0000;
            if (hit(i_paddr, itc_pkg::IDX_CTRL))
                o_prdata[7:0] <= {1'b0, fmt24, sel, single, match, cnt_en, clk_en};
            if (hit(i_paddr, itc_pkg::IDX_HTH)) o_prdata[7:0] <= tod_bus.hth;
            if (hit(i_paddr, itc_pkg::IDX_SEC)) o_prdata[7:0] <= tod_bus.sec;
            if (hit(i_paddr, itc_pkg::IDX_MIN)) o_prdata[7:0] <= tod_bus.min;
            if (hit(i_paddr, itc_pkg::IDX_HOUR)) o_prdata[7:0] <= tod_bus.hr;
            if (hit(i_paddr, itc_pkg::IDX_CMP)) o_prdata[7:0] <= cmp;
            if (hit(i_paddr, itc_pkg::IDX_IST)) o_prdata[0] <= ist;
            if (hit(i_paddr, itc_pkg::IDX_IEN)) o_prdata[0] <= ien;
        end else begin
            o_prdata <= 32'h0000_0000;
        end
    end

    // control fields written by software
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            fmt24 <= itc_pkg::RST_CTRL[itc_pkg::BIT_FMT];
            sel <= itc_pkg::RST_CTRL[itc_pkg::BIT_SEL_HI:itc_pkg::BIT_SEL_LO];
            single <= itc_pkg::RST_CTRL[itc_pkg::BIT_SINGLE];
            clk_en <= itc_pkg::RST_CTRL[itc_pkg::BIT_CLK_EN];
        end else if (wr_ctrl) begin
            fmt24 <= i_pwdata[itc_pkg::BIT_FMT];
            sel <= i_pwdata[itc_pkg::BIT_SEL_HI:itc_pkg::BIT_SEL_LO];
            single <= i_pwdata[itc_pkg::BIT_SINGLE];
            clk_en <= i_pwdata[itc_pkg::BIT_CLK_EN];
        end
    end

    // count enable: software write wins, single shot clears it
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            cnt_en <= itc_pkg::RST_CTRL[itc_pkg::BIT_CNT_EN];
        end else if (wr_ctrl) begin
            cnt_en <= i_pwdata[itc_pkg::BIT_CNT_EN];
        end else if (hit_now & single) begin
            cnt_en <= 1'b0;
        end
    end

    // match flag: sticky, cleared by writing zero, set wins
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            match <= itc_pkg::RST_CTRL[itc_pkg::BIT_MATCH];
        end else if (hit_now) begin
            match <= 1'b1;
        end else if (wr_ctrl & ~i_pwdata[itc_pkg::BIT_MATCH]) begin
            match <= 1'b0;
        end
    end

    // compare value
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            cmp <= itc_pkg::RST_CMP;
        end else if (wr_fire & hit(i_paddr, itc_pkg::IDX_CMP)) begin
            cmp <= i_pwdata[7:0];
        end
    end

    // interval counter: cleared when disabled, reloads on a match
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            icnt <= 8'h00;
        end else if (~cnt_en | hit_now) begin
            icnt <= 8'h00;
        end else if (adv) begin
            icnt <= nxt;
        end
    end

    // interrupt status, clear and enable
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            ist <= 1'b0;
            ien <= 1'b0;
        end else begin
            if (hit_now) begin
                ist <= 1'b1;
            end else if (wr_fire & hit(i_paddr, itc_pkg::IDX_ICLR) & i_pwdata[0]) begin
                ist <= 1'b0;
            end
            if (wr_fire & hit(i_paddr, itc_pkg::IDX_IEN)) ien <= i_pwdata[0];
        end
    end

    // interrupt line and power-down wake
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_irq <= 1'b0;
            o_wake <= 1'b0;
            o_wake_vector <= 16'h0000;
        end else begin
            o_irq <= ist & ien;
            o_wake <= i_power_down & ist & ien;
            o_wake_vector <= (i_power_down & ist & ien) ? itc_pkg::WAKE_VEC : 16'h0000;
        end
    end

    // checks
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_n);

    sequence s_cmp_write;
        wr_fire && hit(i_paddr, itc_pkg::IDX_CMP);
    endsequence

    sequence s_hth_preload;
        tod_bus.wr[0] && !tod_bus.tick;
    endsequence

    sequence s_enabled_match;
        hit_now && ien;
    endsequence

    property p_step;
        adv && !hit_now && cnt_en |=> icnt == 8'($past(icnt) + 8'h01);
    endproperty
    a_step: assert property (p_step) else $error("interval step wrong");

    property p_reload;
        hit_now |=> icnt == 8'h00 && match && ist;
    endproperty
    a_reload: assert property (p_reload) else $error("match did not reload");

    property p_irq;
        s_enabled_match ##1 ien |=> o_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("no interrupt after match");

    property p_wake;
        s_enabled_match ##1 (ien && i_power_down) |=>
            o_wake && o_wake_vector == itc_pkg::WAKE_VEC;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake with vector");

    property p_single;
        hit_now && single && !wr_ctrl |=> !cnt_en ##1 icnt == 8'h00;
    endproperty
    a_single: assert property (p_single) else $error("single shot kept running");

    property p_sticky;
        match && !wr_ctrl |=> match;
    endproperty
    a_sticky: assert property (p_sticky) else $error("match flag lost");

    property p_cmp;
        s_cmp_write |=> cmp == $past(i_pwdata[7:0]);
    endproperty
    a_cmp: assert property (p_cmp) else $error("compare value not stored");

    property p_preload;
        s_hth_preload |=> tod_bus.hth == $past(i_pwdata[7:0]);
    endproperty
    a_preload: assert property (p_preload) else $error("time preload lost");

    property p_unmapped;
        access && !o_pready && !mapped |=> o_pready && o_pslverr;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("no error on bad address");

    property p_tick_gap;
        tick128 |=> !tick128;
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("tick is not a pulse");

    sequence s_hth_last;
        tod_bus.run && tod_bus.tick && tod_bus.hth == itc_pkg::HTH_MAX;
    endsequence

    property p_hth_wrap;
        s_hth_last |=> tod_bus.hth == 8'h00 && tod_bus.ovf[1];
    endproperty
    a_hth_wrap: assert property (p_hth_wrap) else $error("hundredths no wrap");

    property p_hth_step;
        tod_bus.run && tod_bus.tick && tod_bus.hth != itc_pkg::HTH_MAX |=>
            tod_bus.hth == 8'($past(tod_bus.hth) + 8'h01);
    endproperty
    a_hth_step: assert property (p_hth_step) else $error("hundredths no step");

    property p_run_hold;
        tod_bus.run && !tod_bus.tick |=> tod_bus.hth == $past(tod_bus.hth);
    endproperty
    a_run_hold: assert property (p_run_hold) else $error("time changed off tick");

    property p_min_roll;
        tod_bus.ovf[2] |-> tod_bus.sec == 8'h00 && tod_bus.hth == 8'h00;
    endproperty
    a_min_roll: assert property (p_min_roll) else $error("minute carry wrong");

    property p_idle_zero;
        !cnt_en |=> icnt == 8'h00;
    endproperty
    a_idle_zero: assert property (p_idle_zero) else $error("idle counter moved");

    property p_match_cause;
        $rose(match) |-> $past(hit_now);
    endproperty
    a_match_cause: assert property (p_match_cause) else $error("flag without match");

    property p_ist_cause;
        $rose(ist) |-> $past(hit_now);
    endproperty
    a_ist_cause: assert property (p_ist_cause) else $error("status without match");

    property p_irq_follow;
        ist && ien |=> o_irq;
    endproperty
    a_irq_follow: assert property (p_irq_follow) else $error("irq not following");

    property p_irq_mask;
        !ien |=> !o_irq;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("masked irq raised");

    property p_vec_idle;
        !o_wake |-> o_wake_vector == 16'h0000;
    endproperty
    a_vec_idle: assert property (p_vec_idle) else $error("vector without wake");

    property p_wake_irq;
        o_wake |-> o_irq;
    endproperty
    a_wake_irq: assert property (p_wake_irq) else $error("wake without irq");

    property p_ready_pulse;
        o_pready |=> !o_pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");

    property p_ready_wait;
        access && !o_pready |=> o_pready;
    endproperty
    a_ready_wait: assert property (p_ready_wait) else $error("ready missing");

    property p_err_ready;
        o_pslverr |-> o_pready;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("error without ready");

    property p_rdata_idle;
        !o_pready |-> o_prdata == 32'h0000_0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("idle read data");
endmodule : itc_top
`default_nettype wire

// ---- dv/itc_top_tb.sv ----
// self-checking bench for the interval counter unit over apb
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b, m) begin compares++; if ((a) !== (b)) begin err_total++; \
    $display("CHECK FAILED t=%0t %s", $time, m); end end
module itc_top_tb;
    // short tick so that the counts fit a short run
    localparam int TC = 8;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic power_down = 1'b0;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic irq;
    logic wake;
    logic [15:0] wvec;
    int err_total = 0;
    int compares = 0;
    int cyc;
    logic [15:0] seed = 16'h0DD6;
    logic [31:0] rd;
    logic er;
    logic [7:0] n;
    logic [7:0] s;
    logic [7:0] ridx [8] = '{itc_pkg::IDX_CTRL, itc_pkg::IDX_HTH, itc_pkg::IDX_SEC,
        itc_pkg::IDX_MIN, itc_pkg::IDX_HOUR, itc_pkg::IDX_CMP, itc_pkg::IDX_IST,
        itc_pkg::IDX_IEN};

    // free-running core clock, 4 ns period
    always #2 ref_clk = ~ref_clk;

    itc_top #(.TICK_CYCLES(TC)) dut (
        .i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
        .o_prdata(prdata), .o_pslverr(pslverr), .i_power_down(power_down),
        .o_irq(irq), .o_wake(wake), .o_wake_vector(wvec)
    );

    // pseudo-random source for data and compare values
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr_next

    // true when a wait length lies inside the expected window
    function automatic logic in_win(input int c, input int lo, input int hi);
        return (c >= lo && c <= hi) ? 1'b1 : 1'b0;
    endfunction : in_win

    // one apb transfer, held until ready is sampled high
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        int k;
        @(posedge ref_clk);
        seed = lfsr_next(seed);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= {seed, 8'h00, wd};
        @(posedge ref_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        `CHK(pready, 1'b1, "no ready")
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // bounded wait for irq or wake
    task automatic wait_sig(input logic sel_wake, input int lim);
        cyc = 0;
        while (((sel_wake ? wake : irq) !== 1'b1) && cyc < lim) begin
            @(posedge ref_clk);
            cyc++;
        end
    endtask : wait_sig

    // stop, preload the last hundredth of an hour, start and wait for irq
    task automatic arm(input logic [7:0] ctl);
        apb(1'b1, itc_pkg::IDX_CTRL, 8'h00);
        apb(1'b1, itc_pkg::IDX_ICLR, 8'h01);
        apb(1'b1, itc_pkg::IDX_HTH, itc_pkg::HTH_MAX);
        apb(1'b1, itc_pkg::IDX_SEC, itc_pkg::SEC_MAX);
        apb(1'b1, itc_pkg::IDX_MIN, itc_pkg::MIN_MAX);
        apb(1'b1, itc_pkg::IDX_HOUR, itc_pkg::HR24_MAX);
        apb(1'b1, itc_pkg::IDX_CTRL, ctl);
        wait_sig(1'b0, 2 * TC + 20);
    endtask : arm

    // verdict and end of run
    task automatic wrap_up;
        if (err_total == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : wrap_up

    // watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_total++;
        $display("CHECK FAILED t=%0t timeout", $time);
        wrap_up();
    end

    // main sequence
    initial begin
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, ridx[i], 8'h00);
            `CHK(rd, 32'h0000_0000, "reset value")
        end
        apb(1'b0, 8'hA0, 8'h00);
        `CHK({er, rd}, {1'b1, 32'h0000_0000}, "unmapped access")
        // compare value boundaries and random values
        for (int i = 0; i < 4; i++) begin
            n = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : seed[7:0];
            apb(1'b1, itc_pkg::IDX_CMP, n);
            apb(1'b0, itc_pkg::IDX_CMP, 8'h00);
            `CHK(rd, {24'h00_0000, n}, "compare readback")
        end
        // time preload while stopped, then counting from it
        s = 8'(seed % 60);
        apb(1'b1, itc_pkg::IDX_CTRL, 8'h00);
        apb(1'b1, itc_pkg::IDX_HTH, 8'h00);
        apb(1'b1, itc_pkg::IDX_SEC, s);
        apb(1'b0, itc_pkg::IDX_SEC, 8'h00);
        `CHK(rd, {24'h00_0000, s}, "seconds preload")
        apb(1'b1, itc_pkg::IDX_CTRL, 8'h01);
        apb(1'b1, itc_pkg::IDX_SEC, s ^ 8'h01);
        apb(1'b0, itc_pkg::IDX_SEC, 8'h00);
        `CHK(rd, {24'h00_0000, s}, "seconds write while running")
        repeat (5 * TC) @(posedge ref_clk);
        apb(1'b0, itc_pkg::IDX_HTH, 8'h00);
        `CHK(in_win(int'(rd), 4, 12), 1'b1, "hundredths advance")
        // interval match on the tick time base
        n = 8'h02 + {6'h00, seed[1:0]};
        apb(1'b1, itc_pkg::IDX_IEN, 8'h01);
        apb(1'b1, itc_pkg::IDX_CMP, n);
        apb(1'b1, itc_pkg::IDX_CTRL, 8'h03);
        wait_sig(1'b0, (n + 2) * TC + 20);
        `CHK(in_win(cyc, (n - 1) * TC, n * TC + 8), 1'b1, "tick match time")
        apb(1'b0, itc_pkg::IDX_CTRL, 8'h00);
        `CHK(rd[itc_pkg::BIT_MATCH], 1'b1, "match flag")
        apb(1'b0, itc_pkg::IDX_IST, 8'h00);
        `CHK(rd[0], 1'b1, "status bit")
        repeat (3 * TC) @(posedge ref_clk);
        `CHK(irq, 1'b1, "irq holds")
        // stop counting first, writing one keeps the flag
        apb(1'b1, itc_pkg::IDX_CTRL, 8'h05);
        apb(1'b1, itc_pkg::IDX_ICLR, 8'h01);
        repeat (2) @(posedge ref_clk);
        `CHK(irq, 1'b0, "irq after clear")
        apb(1'b0, itc_pkg::IDX_CTRL, 8'h00);
        `CHK(rd, 32'h0000_0005, "flag kept by one")
        apb(1'b1, itc_pkg::IDX_CTRL, 8'h01);
        apb(1'b0, itc_pkg::IDX_CTRL, 8'h00);
        `CHK(rd[itc_pkg::BIT_MATCH], 1'b0, "flag after clear")
        // masked interrupt: status sets, line stays low
        apb(1'b1, itc_pkg::IDX_IEN, 8'h00);
        apb(1'b1, itc_pkg::IDX_CTRL, 8'h03);
        repeat ((n + 1) * TC + 8) @(posedge ref_clk);
        apb(1'b0, itc_pkg::IDX_IST, 8'h00);
        `CHK(rd[0], 1'b1, "masked status")
        `CHK(irq, 1'b0, "masked irq")
        // match during power-down wakes with the service address
        apb(1'b1, itc_pkg::IDX_CTRL, 8'h01);
        apb(1'b1, itc_pkg::IDX_ICLR, 8'h01);
        apb(1'b1, itc_pkg::IDX_IEN, 8'h01);
        power_down <= 1'b1;
        apb(1'b1, itc_pkg::IDX_CTRL, 8'h03);
        wait_sig(1'b1, (n + 2) * TC + 20);
        `CHK(in_win(cyc, (n - 1) * TC, n * TC + 8), 1'b1, "wake time")
        `CHK(wvec, itc_pkg::WAKE_VEC, "wake vector")
        power_down <= 1'b0;
        repeat (3) @(posedge ref_clk);
        `CHK({wake, wvec}, 17'h0_0000, "wake after power-up")
        // second time base: one hundredths overflow per event
        apb(1'b1, itc_pkg::IDX_CTRL, 8'h00);
        apb(1'b1, itc_pkg::IDX_ICLR, 8'h01);
        apb(1'b1, itc_pkg::IDX_HTH, 8'h00);
        apb(1'b1, itc_pkg::IDX_CMP, 8'h01);
        apb(1'b1, itc_pkg::IDX_CTRL, 8'h13);
        wait_sig(1'b0, 130 * TC + 20);
        `CHK(in_win(cyc, 126 * TC, 128 * TC + 10), 1'b1, "second match time")
        // single shot: one match, then count enable drops by itself
        apb(1'b1, itc_pkg::IDX_CTRL, 8'h01);
        apb(1'b1, itc_pkg::IDX_ICLR, 8'h01);
        apb(1'b1, itc_pkg::IDX_CMP, n);
        apb(1'b1, itc_pkg::IDX_CTRL, 8'h0B);
        wait_sig(1'b0, (n + 2) * TC + 20);
        `CHK(in_win(cyc, (n - 1) * TC, n * TC + 8), 1'b1, "single shot time")
        apb(1'b0, itc_pkg::IDX_CTRL, 8'h00);
        `CHK(rd, 32'h0000_000D, "single shot stops")
        // minute base in 24-hour format, then hour base in 255-hour format
        apb(1'b1, itc_pkg::IDX_CMP, 8'h01);
        arm(8'h63);
        `CHK(in_win(cyc, 1, TC + 8), 1'b1, "minute match time")
        apb(1'b0, itc_pkg::IDX_HOUR, 8'h00);
        `CHK(rd, 32'h0000_0000, "24-hour wrap")
        arm(8'h33);
        `CHK(in_win(cyc, 1, TC + 8), 1'b1, "hour match time")
        apb(1'b0, itc_pkg::IDX_HOUR, 8'h00);
        `CHK(rd, 32'h0000_0018, "255-hour count")
        wrap_up();
    end
endmodule : itc_top_tb
`undef CHK
`default_nettype wire
